// ---- pkg/awhbp_pkg.sv ----
// Constants of the ARINC word host byte port.
// Overview of operation
// - After master reset, the receiver ignores line bits until one word gap is seen.
// - Error flags clear only on a status read or a master reset.
// - An error flag suspends the transmitter or receiver it belongs to.
// - Byte mode: a data byte write drives buffer-ready and idle pins low.
// - Feature select low: control bit 5 picks parity or data for bit 32.
// - Status bit 0 is buffer ready, bit 2 idle, bit 7 underwrite error.
// - Byte mode: status bit 0 reads low while a byte is pending, high when one fits.
// - Transmit bytes load low word bits first, word bit 1 on data line 0.
// - Feature select high, only control bit 2 set: 32-bit receive.
// - 32-bit receive raises the ready and first-char pins per word; host then reads four bytes.
// - Feature select high, control bits 5 and 2 set: 8-bit receive.
// - Byte receive: a data read clears status bit 1 and the ready pin.
// - Select high for status read and control write, low for data; no control readback.
// - Idle pin falls when a word starts and rises when it is fully sent.
// - Loaded buffer, enabled transmitter and low clear-to-send start a word.
// - Byte mode: next byte missing at end of a byte's 8th bit sets underwrite.
package awhbp_pkg;
  // Control word fields
  localparam int CR_TX_EN  = 0;
  localparam int CR_RX_EN  = 2;
  localparam int CR_PARSEL = 5;
  localparam logic [7:0] CR_RESET = 8'h25;
  // Status word fields
  localparam int SR_TX_RDY   = 0;
  localparam int SR_RX_RDY   = 1;
  localparam int SR_TX_IDLE  = 2;
  localparam int SR_PAR_ERR  = 3;
  localparam int SR_OVR_ERR  = 4;
  localparam int SR_FRM_ERR  = 5;
  localparam int SR_FIRST    = 6;
  localparam int SR_UND_ERR  = 7;
  // Word geometry
  localparam int WORD_BITS   = 32;
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int BIT_TIME_NS   = 10000;
  localparam int GAP_TIME_NS   = 20000;
  localparam int BIT_CYC = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Transmit sequencer states
  typedef enum logic [0:0] {TX_IDLE, TX_SEND} awhbp_tx_state_type;
endpackage

// ---- design/awhbp_tx_bit.sv ----
// Return-to-zero line driver for one transmitted bit.
`timescale 1ns/1ps
`default_nettype none
module awhbp_tx_bit #(
  parameter int BIT_CYC = awhbp_pkg::BIT_CYC
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  input  wire logic clear_i,
  // Bit request
  input  wire logic start_i,
  input  wire logic bit_i,
  output logic      done_o,
  // Line
  output logic      txd_zero_o,
  output logic      txd_one_o
);
  localparam int CW = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2 - 1);
  localparam logic [CW-1:0] LAST = CW'(BIT_CYC - 1);
  logic          busy_r;
  logic [CW-1:0] cnt_r;

  // High half then null half; done pulses as the bit cell ends
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_r     <= 1'b0;
      cnt_r      <= '0;
      done_o     <= 1'b0;
      txd_zero_o <= 1'b0;
      txd_one_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (clear_i) begin
        busy_r     <= 1'b0;
        txd_zero_o <= 1'b0;
        txd_one_o  <= 1'b0;
      end else if (start_i && !busy_r) begin
        busy_r     <= 1'b1;
        cnt_r      <= '0;
        txd_one_o  <= bit_i;
        txd_zero_o <= !bit_i;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == HALF) begin
          txd_zero_o <= 1'b0;
          txd_one_o  <= 1'b0;
        end
        if (cnt_r == LAST) begin
          busy_r <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/awhbp_rx_bit.sv ----
// Line watcher: bit strobes on leaving null, and word gap detection.
`timescale 1ns/1ps
`default_nettype none
module awhbp_rx_bit #(
  parameter int GAP_CYC = awhbp_pkg::GAP_CYC
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  // Line
  input  wire logic rxd_zero_i,
  input  wire logic rxd_one_i,
  // Events
  output logic      bit_stb_o,
  output logic      bit_val_o,
  output logic      gap_o
);
  localparam int CW = $clog2(GAP_CYC + 1);
  localparam logic [CW-1:0] GAP_LAST = CW'(GAP_CYC - 1);
  logic          null_r;
  logic [CW-1:0] null_cnt_r;
  logic          line_null;
  assign line_null = !rxd_zero_i && !rxd_one_i;

  // Gap fires once per null stretch, so a long idle line gives one pulse
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      null_r     <= 1'b1;
      null_cnt_r <= '0;
      bit_stb_o  <= 1'b0;
      bit_val_o  <= 1'b0;
      gap_o      <= 1'b0;
    end else begin
      null_r    <= line_null;
      bit_stb_o <= null_r && !line_null;
      bit_val_o <= rxd_one_i;
      gap_o     <= line_null && (null_cnt_r == GAP_LAST);
      if (!line_null) begin
        null_cnt_r <= '0;
      end else if (null_cnt_r != GAP_CYC[CW-1:0]) begin
        null_cnt_r <= null_cnt_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/awhbp_top.sv ----
// Host byte port of the ARINC word transmitter and receiver.
`timescale 1ns/1ps
`default_nettype none
module awhbp_top #(
  parameter int BIT_CYC = awhbp_pkg::BIT_CYC,
  parameter int GAP_CYC = awhbp_pkg::GAP_CYC
) (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  input  wire logic       master_reset_pin_i,
  // Register port: sel high is control/status, low is data
  input  wire logic       sel_ctl_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Mode and gate pins
  input  wire logic       hw_feature_select_pin_i,
  input  wire logic       cts_n_i,
  // Serial line
  output logic            txd_zero_o,
  output logic            txd_one_o,
  input  wire logic       rxd_zero_i,
  input  wire logic       rxd_one_i,
  // Flag pins
  output logic            tx_buffer_ready_pin_o,
  output logic            tx_idle_pin_o,
  output logic            rx_word_ready_pin_o,
  output logic            first_char_flag_pin_o,
  output logic            any_error_pin_o
);
  logic [7:0] ctl_r;
  logic       mr;
  logic       mode32, par_en, par_sel;
  logic       wr_data, rd_data, rd_stat;
  // Transmit state
  awhbp_pkg::awhbp_tx_state_type tx_state_r;
  logic [31:0] tx_word_r;
  logic [2:0]  tx_wr_idx_r;
  logic [4:0]  tx_pos_r;
  logic        err_und_r;
  logic        tx_go, tx_next, tx_bit, tx_done;
  logic        tx_pending, tx_ready, tx_idle, tx_under;
  logic [2:0]  tx_cur_plus1;
  // Receive state
  logic [31:0] rx_shift_r, rx_shift_nxt, rx_word_r;
  logic [5:0]  rx_cnt_r;
  logic [7:0]  rx_byte_r;
  logic [1:0]  rx_rd_idx_r;
  logic        rx_armed_r, rx_rdy_r, rx_first_r;
  logic        err_par_r, err_ovr_r, err_frm_r;
  logic        rx_err, rx_run, rx_stb, rx_val, rx_gap;
  logic        rx_byte_done, rx_par_bad;
  logic [7:0]  status;

  assign mr      = master_reset_pin_i;
  // Register port decode, control readback does not exist
  assign wr_data = wr_i && !sel_ctl_i;
  assign rd_data = rd_i && !sel_ctl_i;
  assign rd_stat = rd_i && sel_ctl_i;

  // Mode decode from the feature-select pin and control bit 5
  assign mode32  = hw_feature_select_pin_i && !ctl_r[awhbp_pkg::CR_PARSEL];
  assign par_sel = ctl_r[awhbp_pkg::CR_PARSEL];
  assign par_en  = hw_feature_select_pin_i || par_sel;

  // Control word, write-only; master reset reloads the default
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_r <= awhbp_pkg::CR_RESET;
    end else if (mr) begin
      ctl_r <= awhbp_pkg::CR_RESET;
    end else if (wr_i && sel_ctl_i) begin
      ctl_r <= wdata_i;
    end
  end

  // ---------------- Transmitter ----------------
  assign tx_cur_plus1 = {1'b0, tx_pos_r[4:3]} + 3'h1;
  // A byte is pending while written but not yet started on the line
  always_comb begin
    if (tx_state_r == awhbp_pkg::TX_SEND) begin
      tx_pending = tx_wr_idx_r > tx_cur_plus1;
    end else begin
      tx_pending = tx_wr_idx_r != 3'h0;
    end
  end

  // Word mode accepts bytes until four are held; byte mode one at a time
  assign tx_ready = mode32 ? (tx_state_r == awhbp_pkg::TX_IDLE && tx_wr_idx_r != 3'h4)
                           : (!tx_pending && tx_wr_idx_r != 3'h4);
  // Byte mode counts a loaded byte as the start of the word; the go cycle drops it so the pin falls with the line
  assign tx_idle  = (tx_state_r == awhbp_pkg::TX_IDLE) && !tx_go
                    && (mode32 || tx_wr_idx_r == 3'h0);

  // Start needs enable, clear-to-send low and no pending underwrite error
  assign tx_go = (tx_state_r == awhbp_pkg::TX_IDLE) && ctl_r[awhbp_pkg::CR_TX_EN]
                 && !cts_n_i && !err_und_r && !mr
                 && (mode32 ? (tx_wr_idx_r == 3'h4) : (tx_wr_idx_r != 3'h0));

  // Byte mode: the following byte must already be in when a byte ends
  assign tx_under = !mode32 && (tx_pos_r[2:0] == 3'h7) && (tx_pos_r != 5'd31)
                    && (tx_wr_idx_r <= tx_cur_plus1);

  assign tx_next = (tx_state_r == awhbp_pkg::TX_SEND) && tx_done
                   && (tx_pos_r != 5'd31) && !tx_under && !mr;

  // Bit 32 carries odd parity or the host's own bit
  always_comb begin
    logic [4:0] pos;
    pos = tx_go ? 5'd0 : (tx_pos_r + 5'd1);
    if (pos == 5'd31 && par_en) begin
      tx_bit = ~^tx_word_r[30:0];
    end else begin
      tx_bit = tx_word_r[pos];
    end
  end

  // Byte loading, least significant word bits first
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_word_r <= 32'h0000_0000;
    end else if (mr) begin
      tx_word_r <= 32'h0000_0000;
    end else if (wr_data && tx_wr_idx_r != 3'h4) begin
      tx_word_r[8*tx_wr_idx_r[1:0] +: 8] <= wdata_i;
    end
  end

  // Transmit sequencer: bit position, byte count and state
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_state_r  <= awhbp_pkg::TX_IDLE;
      tx_pos_r    <= 5'd0;
      tx_wr_idx_r <= 3'h0;
    end else if (mr) begin
      tx_state_r  <= awhbp_pkg::TX_IDLE;
      tx_pos_r    <= 5'd0;
      tx_wr_idx_r <= 3'h0;
    end else begin
      if (wr_data && tx_wr_idx_r != 3'h4) begin
        tx_wr_idx_r <= tx_wr_idx_r + 3'h1;
      end
      case (tx_state_r)
        awhbp_pkg::TX_IDLE: begin
          if (tx_go) begin
            tx_state_r <= awhbp_pkg::TX_SEND;
            tx_pos_r   <= 5'd0;
          end
        end
        awhbp_pkg::TX_SEND: begin
          if (tx_done) begin
            if (tx_pos_r == 5'd31 || tx_under) begin
              // Word complete or aborted: buffer empties either way
              tx_state_r  <= awhbp_pkg::TX_IDLE;
              tx_pos_r    <= 5'd0;
              tx_wr_idx_r <= 3'h0;
            end else begin
              tx_pos_r <= tx_pos_r + 5'd1;
            end
          end
        end
        default: begin
          tx_state_r <= awhbp_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Underwrite flag; raising it wins over a clearing status read
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_und_r <= 1'b0;
    end else if (mr) begin
      err_und_r <= 1'b0;
    end else if (tx_state_r == awhbp_pkg::TX_SEND && tx_done && tx_under) begin
      err_und_r <= 1'b1;
    end else if (rd_stat) begin
      err_und_r <= 1'b0;
    end
  end

  awhbp_tx_bit #(
    .BIT_CYC (BIT_CYC)
  ) u_tx_bit (
    .clk_sys_i  (clk_sys_i),
    .arst_n_i   (arst_n_i),
    .clear_i    (mr),
    .start_i    (tx_go || tx_next),
    .bit_i      (tx_bit),
    .done_o     (tx_done),
    .txd_zero_o (txd_zero_o),
    .txd_one_o  (txd_one_o)
  );

  // ---------------- Receiver ----------------
  awhbp_rx_bit #(
    .GAP_CYC (GAP_CYC)
  ) u_rx_bit (
    .clk_sys_i  (clk_sys_i),
    .arst_n_i   (arst_n_i),
    .rxd_zero_i (rxd_zero_i),
    .rxd_one_i  (rxd_one_i),
    .bit_stb_o  (rx_stb),
    .bit_val_o  (rx_val),
    .gap_o      (rx_gap)
  );

  assign rx_err = err_par_r || err_ovr_r || err_frm_r;
  // Bits count only once armed, enabled and free of errors
  assign rx_run = ctl_r[awhbp_pkg::CR_RX_EN] && rx_armed_r && !rx_err;

  always_comb begin
    rx_shift_nxt = rx_shift_r;
    if (rx_cnt_r < 6'd32) begin
      rx_shift_nxt[rx_cnt_r[4:0]] = rx_val;
    end
  end

  // Byte mode hands each byte over as its 8th bit lands
  assign rx_byte_done = rx_run && rx_stb && !mode32 && rx_cnt_r < 6'd32
                        && rx_cnt_r[2:0] == 3'h7;
  // Even parity across the whole word is an error when parity is on
  assign rx_par_bad = par_en && !(^rx_shift_nxt);

  // Receiver arms on the first gap after reset; the first bit after it may start a word
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_armed_r <= 1'b0;
    end else if (mr) begin
      rx_armed_r <= 1'b0;
    end else if (rx_gap) begin
      rx_armed_r <= 1'b1;
    end
  end

  // Bit assembly; a gap ends the word
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_shift_r <= 32'h0000_0000;
      rx_cnt_r   <= 6'd0;
    end else if (mr || rx_gap) begin
      rx_cnt_r <= 6'd0;
    end else if (rx_run && rx_stb) begin
      rx_shift_r <= rx_shift_nxt;
      // Extra bits park the count above 32 so framing fails
      if (rx_cnt_r != 6'd33) begin
        rx_cnt_r <= rx_cnt_r + 6'd1;
      end
    end
  end

  // Receive buffers, read pointer and ready flags; a new arrival wins over a read
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_word_r   <= 32'h0000_0000;
      rx_byte_r   <= 8'h00;
      rx_rd_idx_r <= 2'd0;
      rx_rdy_r    <= 1'b0;
      rx_first_r  <= 1'b0;
    end else if (mr) begin
      rx_rd_idx_r <= 2'd0;
      rx_rdy_r    <= 1'b0;
      rx_first_r  <= 1'b0;
    end else begin
      if (rd_data) begin
        if (!mode32) begin
          rx_rdy_r   <= 1'b0;
          rx_first_r <= 1'b0;
        end else begin
          rx_rd_idx_r <= rx_rd_idx_r + 2'd1;
          if (rx_rd_idx_r == 2'd3) begin
            rx_rdy_r   <= 1'b0;
            rx_first_r <= 1'b0;
          end
        end
      end
      if (rx_byte_done) begin
        rx_byte_r  <= rx_shift_nxt[8*rx_cnt_r[4:3] +: 8];
        rx_rdy_r   <= 1'b1;
        rx_first_r <= rx_cnt_r[4:3] == 2'd0;
      end
      if (rx_gap && rx_run && mode32 && rx_cnt_r == 6'd32 && !rx_par_bad) begin
        rx_word_r   <= rx_shift_r;
        rx_rd_idx_r <= 2'd0;
        rx_rdy_r    <= 1'b1;
        rx_first_r  <= 1'b1;
      end
    end
  end

  // Receive error flags; setting wins over the clearing status read
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_par_r <= 1'b0;
      err_ovr_r <= 1'b0;
      err_frm_r <= 1'b0;
    end else if (mr) begin
      err_par_r <= 1'b0;
      err_ovr_r <= 1'b0;
      err_frm_r <= 1'b0;
    end else begin
      if (rd_stat) begin
        err_par_r <= 1'b0;
        err_ovr_r <= 1'b0;
        err_frm_r <= 1'b0;
      end
      if (rx_byte_done && rx_cnt_r == 6'd31 && rx_par_bad) begin
        err_par_r <= 1'b1;
      end
      if (rx_byte_done && rx_rdy_r && !rd_data) begin
        err_ovr_r <= 1'b1;
      end
      if (rx_gap && rx_run && rx_cnt_r != 6'd0) begin
        if (rx_cnt_r != 6'd32) begin
          err_frm_r <= 1'b1;
        end else if (mode32 && rx_par_bad) begin
          err_par_r <= 1'b1;
        end else if (mode32 && rx_rdy_r) begin
          err_ovr_r <= 1'b1;
        end
      end
    end
  end

  // ---------------- Host side outputs ----------------
  always_comb begin
    status = 8'h00;
    status[awhbp_pkg::SR_TX_RDY]  = tx_ready;
    status[awhbp_pkg::SR_RX_RDY]  = rx_rdy_r;
    status[awhbp_pkg::SR_TX_IDLE] = tx_idle;
    status[awhbp_pkg::SR_PAR_ERR] = err_par_r;
    status[awhbp_pkg::SR_OVR_ERR] = err_ovr_r;
    status[awhbp_pkg::SR_FRM_ERR] = err_frm_r;
    status[awhbp_pkg::SR_FIRST]   = rx_first_r;
    status[awhbp_pkg::SR_UND_ERR] = err_und_r;
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_stat) begin
      rdata_o <= status;
    end else if (rd_data) begin
      rdata_o <= mode32 ? rx_word_r[8*rx_rd_idx_r +: 8] : rx_byte_r;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Flag pins registered, one cycle behind the internal state
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_buffer_ready_pin_o <= 1'b1;
      tx_idle_pin_o         <= 1'b1;
      rx_word_ready_pin_o   <= 1'b0;
      first_char_flag_pin_o <= 1'b0;
      any_error_pin_o       <= 1'b0;
    end else begin
      tx_buffer_ready_pin_o <= tx_ready;
      tx_idle_pin_o         <= tx_idle;
      rx_word_ready_pin_o   <= rx_rdy_r;
      first_char_flag_pin_o <= rx_first_r;
      any_error_pin_o       <= rx_err || err_und_r;
    end
  end
endmodule
`default_nettype wire

// ---- tb/awhbp_checker.sv ----
// Assertion checker bound to the host byte port top.
`timescale 1ns/1ps
`default_nettype none
module awhbp_checker (
  // Clock and resets
  input wire logic       clk_sys_i,
  input wire logic       arst_n_i,
  input wire logic       master_reset_pin_i,
  // Register port and mode
  input wire logic       sel_ctl_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       hw_feature_select_pin_i,
  // Line and flag pins
  input wire logic       txd_zero_o,
  input wire logic       txd_one_o,
  input wire logic       tx_buffer_ready_pin_o,
  input wire logic       tx_idle_pin_o,
  input wire logic       rx_word_ready_pin_o,
  input wire logic       first_char_flag_pin_o,
  input wire logic       any_error_pin_o
);
  // A status read is the only software path that clears errors
  wire logic stat_rd = rd_i && sel_ctl_i;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  a_status_mirror: assert property (
    stat_rd |=> rdata_o[0] == tx_buffer_ready_pin_o && rdata_o[2] == tx_idle_pin_o
      && rdata_o[1] == rx_word_ready_pin_o && rdata_o[6] == first_char_flag_pin_o
      && (!rdata_o[7] || any_error_pin_o))
    else $error("status byte disagrees with flag pins");
  a_rdata_quiet: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_line_exclusive: assert property (!(txd_zero_o && txd_one_o))
    else $error("both line outputs high");
  a_line_idle: assert property ((txd_zero_o || txd_one_o) |-> !tx_idle_pin_o)
    else $error("line active while idle pin high");
  a_byte_load: assert property (
    wr_i && !sel_ctl_i && !hw_feature_select_pin_i && tx_buffer_ready_pin_o && !any_error_pin_o
      |-> ##2 (!tx_buffer_ready_pin_o && !tx_idle_pin_o))
    else $error("byte load did not drop ready and idle pins");
  a_err_clear: assert property (any_error_pin_o && stat_rd |-> ##2 !any_error_pin_o)
    else $error("status read left error pin high");
  a_err_sticky: assert property (
    $fell(any_error_pin_o) |-> $past(stat_rd, 2) || $past(master_reset_pin_i, 2))
    else $error("error pin cleared without status read or master reset");
  a_mr_init: assert property (master_reset_pin_i |-> ##2 (tx_buffer_ready_pin_o && tx_idle_pin_o
      && !rx_word_ready_pin_o && !first_char_flag_pin_o && !any_error_pin_o))
    else $error("flag pins not initialised by master reset");
  a_first_ready: assert property (first_char_flag_pin_o |-> rx_word_ready_pin_o)
    else $error("first char pin without ready pin");
  // Main scenarios reached
  c_err_read: cover property (any_error_pin_o && stat_rd);
  c_first_char: cover property ($rose(first_char_flag_pin_o));
  c_word_start: cover property ($fell(tx_idle_pin_o));
endmodule
bind awhbp_top awhbp_checker u_checker (
  .clk_sys_i, .arst_n_i, .master_reset_pin_i, .sel_ctl_i, .wr_i, .rd_i, .rdata_o,
  .hw_feature_select_pin_i, .txd_zero_o, .txd_one_o, .tx_buffer_ready_pin_o, .tx_idle_pin_o,
  .rx_word_ready_pin_o, .first_char_flag_pin_o, .any_error_pin_o
);
`default_nettype wire

// ---- tb/awhbp_line_peer.sv ----
// Far-end line peer that sends return-to-zero words to the receiver.
`timescale 1ns/1ps
`default_nettype none
module awhbp_line_peer #(
  parameter int BIT_CYC = 8
) (
  // Clock
  input  wire logic        clk_sys_i,
  // Word request, held only for the launching edge
  input  wire logic        send_i,
  input  wire logic [31:0] word_i,
  // Line
  output logic             rxd_zero_o,
  output logic             rxd_one_o
);
  // Bit 1 first, one half cell active then null so every bit has an edge
  initial begin
    logic [31:0] w;
    rxd_zero_o = 1'b0;
    rxd_one_o = 1'b0;
    forever begin
      @(posedge clk_sys_i);
      if (send_i) begin
        w = word_i;
        for (int i = 0; i < 32; i++) begin
          rxd_one_o <= w[i];
          rxd_zero_o <= !w[i];
          repeat (BIT_CYC / 2) @(posedge clk_sys_i);
          rxd_one_o <= 1'b0;
          rxd_zero_o <= 1'b0;
          repeat (BIT_CYC - BIT_CYC / 2) @(posedge clk_sys_i);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/test_awhbp_top.sv ----
// Self-checking bench for the ARINC word host byte port.
`timescale 1ns/1ps
`default_nettype none
module test_awhbp_top;
  // Short bit cell and gap keep the run brief
  localparam int BC = 8;
  localparam int GC = 20;
  logic        clk_sys_i, arst_n_i, master_reset_pin_i, sel_ctl_i, wr_i, rd_i;
  logic        hw_feature_select_pin_i, cts_n_i, txd_zero_o, txd_one_o, rxd_zero_i, rxd_one_i;
  logic        tx_buffer_ready_pin_o, tx_idle_pin_o, rx_word_ready_pin_o, send, line_q;
  logic        first_char_flag_pin_o, any_error_pin_o;
  logic [7:0]  wdata_i, rdata_o, s;
  logic [31:0] f, g;
  logic        tx_bits[$];
  int          n_fail, checks, k;

  awhbp_top #(.BIT_CYC(BC), .GAP_CYC(GC)) dut (
    .clk_sys_i, .arst_n_i, .master_reset_pin_i, .sel_ctl_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .hw_feature_select_pin_i, .cts_n_i, .txd_zero_o, .txd_one_o, .rxd_zero_i, .rxd_one_i,
    .tx_buffer_ready_pin_o, .tx_idle_pin_o, .rx_word_ready_pin_o, .first_char_flag_pin_o, .any_error_pin_o
  );
  awhbp_line_peer #(.BIT_CYC(BC)) peer (
    .clk_sys_i, .send_i(send), .word_i(f), .rxd_zero_o(rxd_zero_i), .rxd_one_o(rxd_one_i)
  );

  // Clock
  always #25 clk_sys_i = ~clk_sys_i;

  // Transmit model: one bit recorded as the line leaves null
  always @(posedge clk_sys_i) begin
    line_q <= txd_zero_o | txd_one_o;
    if ((txd_zero_o | txd_one_o) && !line_q) tx_bits.push_back(txd_one_o);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // Bus cycles leave one idle cycle so a strobe is never set twice in a step
  task automatic wr(input logic sel, input logic [7:0] d);
    sel_ctl_i <= sel;
    wdata_i <= d;
    wr_i <= 1'b1;
    tick(1);
    wr_i <= 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic sel, output logic [7:0] d);
    sel_ctl_i <= sel;
    rd_i <= 1'b1;
    tick(1);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    tick(1);
  endtask

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Random word with odd parity in bit 32, launched on the line
  task automatic send_word();
    f = $urandom();
    f[31] = ~^f[30:0];
    send <= 1'b1;
    tick(1);
    send <= 1'b0;
  endtask

  // Byte-mode word, paced by the ready pin or by polling status
  task automatic tx_word(input logic [31:0] w, input bit poll, input bit par);
    logic [31:0] got;
    for (int b = 0; b < 4; b++) begin
      wr(1'b0, w[8*b +: 8]);
      tick(1);
      check("ready pin after load", tx_buffer_ready_pin_o, 1'b0);
      check("idle pin after load", tx_idle_pin_o, 1'b0);
      if (b == 0 && cts_n_i) begin
        tick(40);
        check("held by clear to send", tx_bits.size(), 0);
        cts_n_i <= 1'b0;
      end
      if (b < 3 && poll) begin
        rd(1'b1, s);
        check("status ready while pending", s[0], b == 0);
        for (int n = 0; n < 100 && s[0] !== 1'b1; n++) rd(1'b1, s);
      end else if (b < 3) begin
        for (int n = 0; n < 300 && tx_buffer_ready_pin_o !== 1'b1; n++) tick(1);
      end
    end
    for (int n = 0; n < 400 && tx_idle_pin_o !== 1'b1; n++) tick(1);
    check("bits sent", tx_bits.size(), 32);
    for (int i = 0; i < 32; i++) got[i] = tx_bits.pop_front();
    check("sent word", got, {par ? ~^w[30:0] : w[31], w[30:0]});
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog well beyond the expected few thousand cycles
  initial begin
    #500000;
    n_fail++;
    complete_run();
  end

  initial begin
    {clk_sys_i, arst_n_i, master_reset_pin_i, sel_ctl_i, wr_i, rd_i, send, line_q} = '0;
    {hw_feature_select_pin_i, cts_n_i, wdata_i, f} = {2'b01, 40'h0};
    void'($urandom(32'hB5695CF6));
    tick(6);
    arst_n_i <= 1'b1;
    tick(1);
    rd(1'b1, s);
    check("status after reset", s, 8'h05);
    // Transmit: data in bit 32, then parity with status polling
    wr(1'b1, 8'h01);
    tx_word($urandom(), 1'b0, 1'b0);
    wr(1'b1, 8'h21);
    tx_word($urandom(), 1'b1, 1'b1);
    // Underwrite: a word with only its first byte loaded
    wr(1'b0, 8'hA5);
    for (int n = 0; n < 300 && any_error_pin_o !== 1'b1; n++) tick(1);
    k = tx_bits.size();
    wr(1'b0, 8'h5A);
    tick(40);
    check("line quiet on error", tx_bits.size(), k);
    rd(1'b1, s);
    check("underwrite flag", s[awhbp_pkg::SR_UND_ERR], 1'b1);
    rd(1'b1, s);
    check("underwrite cleared", s[awhbp_pkg::SR_UND_ERR], 1'b0);
    check("error pin cleared", any_error_pin_o, 1'b0);
    tx_bits.delete();
    // Master reset, then a word with no gap before it is ignored
    hw_feature_select_pin_i <= 1'b1;
    master_reset_pin_i <= 1'b1;
    tick(1);
    master_reset_pin_i <= 1'b0;
    tick(2);
    wr(1'b1, 8'h04);
    send_word();
    tick(32 * BC + GC + 20);
    check("no word before gap", rx_word_ready_pin_o, 1'b0);
    // 32-bit receive on the ready pin
    send_word();
    for (int n = 0; n < 400 && rx_word_ready_pin_o !== 1'b1; n++) tick(1);
    check("first char pin", first_char_flag_pin_o, 1'b1);
    for (int b = 0; b < 4; b++) begin
      rd(1'b0, s);
      check("word byte", s, f[8*b +: 8]);
    end
    tick(2);
    check("pins after fourth read", {rx_word_ready_pin_o, first_char_flag_pin_o}, 2'b00);
    // 8-bit receive by status polling
    wr(1'b1, 8'h24);
    send_word();
    for (int b = 0; b < 4; b++) begin
      s = 8'h00;
      for (int n = 0; n < 60 && s[1] !== 1'b1; n++) rd(1'b1, s);
      check("first byte flag", s[6], b == 0);
      rd(1'b0, s);
      check("byte", s, f[8*b +: 8]);
      rd(1'b1, s);
      check("ready cleared by read", s[1], 1'b0);
    end
    // Word mode transmit: four buffered bytes, receiver off, parity in bit 32
    wr(1'b1, 8'h01);
    f = $urandom();
    tx_bits.delete();
    for (int b = 0; b < 4; b++) wr(1'b0, f[8*b +: 8]);
    tick(2);
    for (int n = 0; n < 400 && tx_idle_pin_o !== 1'b1; n++) tick(1);
    check("word mode bits", tx_bits.size(), 32);
    for (int i = 0; i < 32; i++) g[i] = tx_bits.pop_front();
    check("word mode sent", g, {~^f[30:0], f[30:0]});
    complete_run();
  end
endmodule
`default_nettype wire
